// *** verilog/sar_ctrl_defs.svh ***
/*
 * Constants for the converter control block: control byte fields, conversion
 * timing and data bus layout.
 * Assumes a 20 MHz reference clock and is included by bare name.
 */
`ifndef SAR_CTRL_DEFS_SVH
`define SAR_CTRL_DEFS_SVH

`define CTRL_POWER_HI_BIT 7
`define CTRL_POWER_LO_BIT 6
`define CTRL_ACQ_BIT 5
`define CTRL_CONFIG_BIT 4
`define CTRL_POLARITY_BIT 3
`define CTRL_CHAN_MSB 2
`define CTRL_CHAN_LSB 0
`define CTRL_RESET_VALUE 8'hc0

`define REF_CLK_PERIOD_NS 50
`define INT_CLK_PERIOD_NS 250
`define INT_CLK_DIV ((`INT_CLK_PERIOD_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define INT_CLK_DIV_W 3

`define HOLD_FALL_EDGES 4'h4
`define CONV_CYCLES 4'hd
`define SAR_BITS 4'ha
`define SAR_START_CODE 10'h200

`define RESULT_W 10
`define FIFO_DEPTH 8

`endif

// *** verilog/sar_ctrl_pkg.sv ***
/*
 * Types of the converter control block: control byte, pin bundle,
 * queued result word and sequencer states.
 * Assumes sar_ctrl_defs.svh is on the include path.
 */
`include "sar_ctrl_defs.svh"

package sar_ctrl_pkg;

   typedef struct packed {
      logic power_clock_sel_hi;
      logic power_clock_sel_lo;
      logic acquisition_select;
      logic input_config_select;
      logic polarity_select;
      logic [2:0] channel_addr;
   } ctrl_byte_t;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic high_byte_select;
      logic conv_clk;
      logic comp;
      logic [7:0] data;
   } pins_t;

   typedef struct packed {
      logic unipolar;
      logic [`RESULT_W-1:0] code;
   } result_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ACQ_INT,
      ST_ACQ_EXT,
      ST_CONV,
      ST_STORE
   } seq_state_t;

endpackage

// *** verilog/sar_adc_ctrl.sv ***
/*
 * Converter control block: host write/read port, track/hold sequencing,
 * successive-approximation stepping, an 8-word result queue and done flag.
 * Assumes the comparator and the host pins are asynchronous to ref_clk_i
 * and that the conversion clock pin is far slower than ref_clk_i.
 */
`timescale 1ns/1ps
`include "sar_ctrl_defs.svh"

module result_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_t;

   fifo_state_t s_q, s_d;
   logic push, pop;

   assign push = in_valid_i && (s_q.count != (AW+1)'(DEPTH));
   assign pop = out_ready_i && (s_q.count != '0);
   assign in_ready_o = (s_q.count != (AW+1)'(DEPTH));
   assign out_valid_o = (s_q.count != '0);
   assign out_data_o = s_q.mem[s_q.rd_ptr];

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data_i;
         s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + AW'(1);
      end
      if (pop) begin
         s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + AW'(1);
      end
      if (push && !pop) begin
         s_d.count = s_q.count + (AW+1)'(1);
      end else if (pop && !push) begin
         s_d.count = s_q.count - (AW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
endmodule // result_fifo

module sar_adc_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic high_byte_select_i,
   input wire logic [7:0] data_i,
   input wire logic conv_clk_i,
   input wire logic comp_i,
   output logic [7:0] data_o,
   output logic data_oe_n_o,
   output logic conv_done_n_o,
   output logic track_o,
   output logic [`RESULT_W-1:0] dac_code_o,
   output logic [2:0] pos_chan_o,
   output logic [2:0] neg_chan_o,
   output logic neg_to_common_o,
   output logic unipolar_o,
   output logic ext_clk_mode_o,
   output logic [1:0] power_mode_o
);

   typedef struct packed {
      sar_ctrl_pkg::pins_t sync1;
      sar_ctrl_pkg::pins_t sync2;
      sar_ctrl_pkg::pins_t prev;
      sar_ctrl_pkg::ctrl_byte_t ctrl;
      logic ext_clk_mode;
      logic [`INT_CLK_DIV_W-1:0] div_cnt;
      sar_ctrl_pkg::seq_state_t state;
      logic [3:0] edge_cnt;
      logic [3:0] bit_cnt;
      logic [`RESULT_W-1:0] code;
      logic [`RESULT_W-1:0] trial;
      sar_ctrl_pkg::result_t result;
      logic unread;
      logic conv_done_n;
      logic track;
      logic [7:0] data_out;
      logic data_oe_n;
   } ctrl_state_t;

   ctrl_state_t s_q, s_d;
   sar_ctrl_pkg::pins_t pins_raw;
   sar_ctrl_pkg::result_t push_word, head_word;
   sar_ctrl_pkg::ctrl_byte_t new_ctrl;
   logic push_valid, push_ready, head_valid, head_take;
   logic write_evt, read_start, read_end, clk_rise, clk_fall;
   logic [`RESULT_W-1:0] conv_code;

   assign pins_raw = '{cs_n: cs_n_i, wr_n: wr_n_i, rd_n: rd_n_i,
                       high_byte_select: high_byte_select_i,
                       conv_clk: conv_clk_i, comp: comp_i, data: data_i};

   // edges are taken between the second sync stage and the copy behind it
   assign write_evt = !s_q.prev.wr_n && s_q.sync2.wr_n && !s_q.prev.cs_n;
   assign read_start = s_q.prev.rd_n && !s_q.sync2.rd_n && !s_q.sync2.cs_n;
   assign read_end = !s_q.prev.rd_n && s_q.sync2.rd_n && !s_q.prev.cs_n;
   assign new_ctrl = s_q.prev.data;

   always_comb begin
      if (s_q.ext_clk_mode) begin
         clk_rise = !s_q.prev.conv_clk && s_q.sync2.conv_clk;
         clk_fall = s_q.prev.conv_clk && !s_q.sync2.conv_clk;
      end else begin
         // internal oscillator: 250 ns period, so four falls span about 1 us
         clk_rise = (s_q.div_cnt == '0);
         clk_fall = (s_q.div_cnt == `INT_CLK_DIV_W'(`INT_CLK_DIV / 2));
      end
   end

   // bipolar results come out two's complement by flipping the msb
   assign conv_code = s_q.ctrl.polarity_select ? s_q.code : {~s_q.code[9], s_q.code[8:0]};
   assign push_word = '{unipolar: s_q.ctrl.polarity_select, code: conv_code};
   assign push_valid = (s_q.state == sar_ctrl_pkg::ST_STORE);
   assign head_take = head_valid && !s_q.unread;

   result_fifo #(
      .WIDTH($bits(sar_ctrl_pkg::result_t)),
      .DEPTH(`FIFO_DEPTH)
   ) u_queue (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_data_i(push_word),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .out_data_o(head_word),
      .out_valid_o(head_valid),
      .out_ready_i(head_take)
   );

   always_comb begin
      s_d = s_q;
      s_d.sync1 = pins_raw;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
      s_d.div_cnt = (s_q.div_cnt == `INT_CLK_DIV_W'(`INT_CLK_DIV - 1)) ? '0
                    : s_q.div_cnt + `INT_CLK_DIV_W'(1);

      case (s_q.state)
         sar_ctrl_pkg::ST_ACQ_INT: begin
            if (clk_fall) begin
               s_d.edge_cnt = s_q.edge_cnt + 4'h1;
               if (s_q.edge_cnt + 4'h1 == `HOLD_FALL_EDGES) begin
                  s_d.track = 1'b0;
                  // the same counter then counts conversion rises, so start it afresh
                  s_d.edge_cnt = '0;
                  s_d.state = sar_ctrl_pkg::ST_CONV;
               end
            end
         end
         sar_ctrl_pkg::ST_CONV: begin
            if (clk_rise) begin
               s_d.edge_cnt = s_q.edge_cnt + 4'h1;
               if (s_q.bit_cnt < `SAR_BITS) begin
                  // keep the trial bit only if the comparator says input is above
                  s_d.code = s_q.sync2.comp ? s_q.trial : s_q.code;
                  s_d.trial = (s_q.sync2.comp ? s_q.trial : s_q.code)
                              | (s_q.trial ^ s_q.code) >> 1;
                  s_d.bit_cnt = s_q.bit_cnt + 4'h1;
               end
               if (s_q.edge_cnt + 4'h1 == `CONV_CYCLES) begin
                  s_d.state = sar_ctrl_pkg::ST_STORE;
               end
            end
         end
         sar_ctrl_pkg::ST_STORE: begin
            // a full queue stalls here rather than losing a finished result
            if (push_ready) begin
               s_d.state = sar_ctrl_pkg::ST_IDLE;
            end
         end
         default: begin
         end
      endcase

      if (read_start) begin
         s_d.conv_done_n = 1'b1;
      end
      if (read_end) begin
         s_d.unread = 1'b0;
      end

      if (write_evt) begin
         s_d.ctrl = new_ctrl;
         if (new_ctrl.power_clock_sel_hi) begin
            s_d.ext_clk_mode = new_ctrl.power_clock_sel_lo;
         end
         s_d.conv_done_n = 1'b1;
         s_d.unread = 1'b0;
         s_d.edge_cnt = '0;
         s_d.bit_cnt = '0;
         s_d.code = '0;
         s_d.trial = `SAR_START_CODE;
         if (s_q.state == sar_ctrl_pkg::ST_ACQ_EXT && !new_ctrl.acquisition_select) begin
            s_d.track = 1'b0;
            s_d.state = sar_ctrl_pkg::ST_CONV;
         end else begin
            s_d.track = 1'b1;
            s_d.state = new_ctrl.acquisition_select ? sar_ctrl_pkg::ST_ACQ_EXT
                        : sar_ctrl_pkg::ST_ACQ_INT;
         end
      end

      // loading a queued result wins over a clear in the same cycle
      if (head_take) begin
         s_d.result = head_word;
         s_d.unread = 1'b1;
         s_d.conv_done_n = 1'b0;
      end

      s_d.data_oe_n = s_q.sync2.cs_n || s_q.sync2.rd_n;
      if (!s_q.sync2.high_byte_select) begin
         s_d.data_out = s_q.result.code[7:0];
      end else begin
         s_d.data_out = {{6{s_q.result.code[9] & ~s_q.result.unipolar}},
                         s_q.result.code[9:8]};
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.sync1 <= '1;
         s_q.sync2 <= '1;
         s_q.prev <= '1;
         s_q.ctrl <= `CTRL_RESET_VALUE;
         s_q.ext_clk_mode <= 1'b1;
         s_q.state <= sar_ctrl_pkg::ST_IDLE;
         s_q.conv_done_n <= 1'b1;
         s_q.data_oe_n <= 1'b1;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign data_o = s_q.data_out;
   assign data_oe_n_o = s_q.data_oe_n;
   assign conv_done_n_o = s_q.conv_done_n;
   assign track_o = s_q.track;
   assign dac_code_o = s_q.trial;
   assign pos_chan_o = s_q.ctrl.channel_addr;
   // pairs are (0,1),(2,3)...; the other member is the low address bit flipped
   assign neg_chan_o = s_q.ctrl.channel_addr ^ 3'h1;
   assign neg_to_common_o = s_q.ctrl.input_config_select;
   assign unipolar_o = s_q.ctrl.polarity_select;
   assign ext_clk_mode_o = s_q.ext_clk_mode;
   assign power_mode_o = {s_q.ctrl.power_clock_sel_hi, s_q.ctrl.power_clock_sel_lo};

endmodule // sar_adc_ctrl

// *** tb/sar_adc_ctrl_checker.sv ***
/* port timing checker for the converter control block.
   bound to every sar_adc_ctrl; assumes ce_i stays high. */
`timescale 1ns/1ps
module sar_adc_ctrl_checker (
   input logic ref_clk_i,
   input logic rst_n_i,
   input logic cs_n_i,
   input logic wr_n_i,
   input logic rd_n_i,
   input logic [7:0] data_i,
   input logic data_oe_n_o,
   input logic conv_done_n_o,
   input logic track_o,
   input logic [2:0] pos_chan_o,
   input logic [2:0] neg_chan_o,
   input logic neg_to_common_o,
   input logic unipolar_o,
   input logic ext_clk_mode_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_track_on_write: assert property ($rose(wr_n_i) && !cs_n_i && data_i[5] |-> ##[1:5] track_o)
      else $error("no tracking after write");
   a_hold_not_early: assert property ($fell(track_o) && !ext_clk_mode_o |-> $past(track_o, 14))
      else $error("hold came too early");
   a_conv_length: assert property ($fell(track_o) && !ext_clk_mode_o
      |-> ##60 conv_done_n_o ##[1:25] !conv_done_n_o)
      else $error("conversion length wrong");
   a_done_on_write: assert property ($rose(track_o) |-> conv_done_n_o)
      else $error("done not cleared by write");
   a_done_on_read: assert property (!rd_n_i && !cs_n_i && !conv_done_n_o |-> ##[1:5] conv_done_n_o)
      else $error("done not cleared by read");
   a_chan_route: assert property ($rose(track_o)
      |-> ##1 pos_chan_o == data_i[2:0] && neg_to_common_o == data_i[4])
      else $error("channel routing wrong");
   a_pair_neg: assert property ($rose(track_o) && !data_i[4] |-> ##1 neg_chan_o == (data_i[2:0] ^ 3'h1))
      else $error("pair partner wrong");
   a_polarity_bit: assert property ($rose(track_o) |-> ##1 unipolar_o == data_i[3])
      else $error("polarity wrong");
   a_clock_mode: assert property ($rose(track_o) && data_i[7] |-> ##1 ext_clk_mode_o == data_i[6])
      else $error("clock mode wrong");
   a_read_drive: assert property ($fell(rd_n_i) && !cs_n_i |-> ##[1:4] !data_oe_n_o)
      else $error("read bus not driven");
   cover property ($fell(conv_done_n_o));
   cover property ($fell(track_o) && ext_clk_mode_o);
   cover property ($rose(track_o) && data_i[5]);
endmodule // sar_adc_ctrl_checker

bind sar_adc_ctrl sar_adc_ctrl_checker sar_adc_ctrl_checker_i (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .cs_n_i(cs_n_i),
   .wr_n_i(wr_n_i),
   .rd_n_i(rd_n_i),
   .data_i(data_i),
   .data_oe_n_o(data_oe_n_o),
   .conv_done_n_o(conv_done_n_o),
   .track_o(track_o),
   .pos_chan_o(pos_chan_o),
   .neg_chan_o(neg_chan_o),
   .neg_to_common_o(neg_to_common_o),
   .unipolar_o(unipolar_o),
   .ext_clk_mode_o(ext_clk_mode_o)
);

// *** tb/sar_adc_ctrl_host.sv ***
/* host processor model: byte bus strobes, conversion clock, analog comparator.
   vin is set by the testbench; the clock runs free at 1/8 of ref_clk_i. */
`timescale 1ns/1ps
module sar_adc_ctrl_host (
   input logic ref_clk_i,
   input logic [9:0] dac_code_i,
   input logic [7:0] rd_data_i,
   output logic cs_n_o,
   output logic wr_n_o,
   output logic rd_n_o,
   output logic high_byte_select_o,
   output logic [7:0] bus_data_o,
   output logic conv_clk_o,
   output logic comp_o
);
   logic [9:0] vin = 10'h000;
   logic [2:0] div = 3'h0;
   initial begin
      {cs_n_o, wr_n_o, rd_n_o, high_byte_select_o} = 4'he;
      bus_data_o = 8'h00;
   end
   assign conv_clk_o = div[2];
   always @(posedge ref_clk_i) begin
      div <= div + 3'h1;
      comp_o <= (vin >= dac_code_i);
   end
   // one pulse starts acquisition, or conversion if bit 5 is clear during external acquisition; lines released to the inverse afterwards
   task automatic wr(input logic [7:0] b);
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      bus_data_o <= b;
      repeat (3) @(posedge ref_clk_i);
      wr_n_o <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      bus_data_o <= ~b;
   endtask
   task automatic rd(input logic h, output logic [7:0] v);
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      rd_n_o <= 1'b0;
      high_byte_select_o <= h;
      repeat (6) @(posedge ref_clk_i);
      v = rd_data_i;
      rd_n_o <= 1'b1;
      cs_n_o <= 1'b1;
      // strobes must stay idle long enough for the synchronisers to see the gap
      repeat (3) @(posedge ref_clk_i);
   endtask
endmodule // sar_adc_ctrl_host

// *** tb/sar_adc_ctrl_test.sv ***
/* self-checking bench for sar_adc_ctrl with the host model on its bus.
   expected codes follow the comparator model: raw code equals vin. */
`timescale 1ns/1ps
module sar_adc_ctrl_test;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic cs_n_i, wr_n_i, rd_n_i, high_byte_select_i, conv_clk_i, comp_i;
   logic [7:0] data_i, data_o;
   logic data_oe_n_o, conv_done_n_o, track_o, neg_to_common_o, unipolar_o, ext_clk_mode_o;
   logic [9:0] dac_code_o;
   logic [2:0] pos_chan_o, neg_chan_o;
   logic [1:0] power_mode_o;
   logic ext_exp = 1'b1;
   int errors = 0;
   int checks_done = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   sar_adc_ctrl sar_adc_ctrl_i (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .cs_n_i(cs_n_i),
      .wr_n_i(wr_n_i),
      .rd_n_i(rd_n_i),
      .high_byte_select_i(high_byte_select_i),
      .data_i(data_i),
      .conv_clk_i(conv_clk_i),
      .comp_i(comp_i),
      .data_o(data_o),
      .data_oe_n_o(data_oe_n_o),
      .conv_done_n_o(conv_done_n_o),
      .track_o(track_o),
      .dac_code_o(dac_code_o),
      .pos_chan_o(pos_chan_o),
      .neg_chan_o(neg_chan_o),
      .neg_to_common_o(neg_to_common_o),
      .unipolar_o(unipolar_o),
      .ext_clk_mode_o(ext_clk_mode_o),
      .power_mode_o(power_mode_o)
   );
   sar_adc_ctrl_host sar_adc_ctrl_host_i (.ref_clk_i(ref_clk_i), .dac_code_i(dac_code_o),
      .rd_data_i(data_o), .cs_n_o(cs_n_i), .wr_n_o(wr_n_i), .rd_n_o(rd_n_i),
      .high_byte_select_o(high_byte_select_i), .bus_data_o(data_i),
      .conv_clk_o(conv_clk_i), .comp_o(comp_i));
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_lvl(input logic on_track, input logic v);
      int n;
      for (n = 0; n < 400 && (on_track ? track_o : conv_done_n_o) !== v; n++)
         @(posedge ref_clk_i);
      if (n == 400) begin
         errors++;
         end_sim();
      end
   endtask
   // one write, wait for the result, read both bytes
   task automatic t_conv(input logic [7:0] c, input logic [9:0] v, input logic trk);
      logic [9:0] r;
      logic [7:0] lo, hi;
      r = c[3] ? v : v ^ 10'h200;
      ext_exp = c[7] ? c[6] : ext_exp;
      sar_adc_ctrl_host_i.vin = v;
      sar_adc_ctrl_host_i.wr(c);
      chk(track_o, trk);
      chk(power_mode_o, c[7:6]);
      chk(ext_clk_mode_o, ext_exp);
      chk(pos_chan_o, c[2:0]);
      chk(neg_to_common_o, c[4]);
      if (!c[4])
         chk(neg_chan_o, {c[2:1], ~c[0]});
      chk(unipolar_o, c[3]);
      wait_lvl(1'b0, 1'b0);
      sar_adc_ctrl_host_i.rd(1'b0, lo);
      sar_adc_ctrl_host_i.rd(1'b1, hi);
      chk(lo, r[7:0]);
      chk(hi, c[3] ? {6'h00, r[9:8]} : {{6{r[9]}}, r[9:8]});
      chk(conv_done_n_o, 1'b1);
   endtask
   task automatic t_reset;
      chk(ext_clk_mode_o, 1'b1);
      chk(power_mode_o, 2'h3);
      chk(conv_done_n_o, 1'b1);
      $display("reset values checked");
   endtask
   task automatic t_modes;
      logic [7:0] cs [5] = '{8'h8f, 8'hd4, 8'h0b, 8'h5e, 8'hc1};
      logic [9:0] vs [5] = '{10'h3a5, 10'h001, 10'h200, 10'h3ff, 10'h155};
      for (int i = 0; i < 5; i++)
         t_conv(cs[i], vs[i], 1'b1);
      $display("mode table done");
   endtask
   task automatic t_host;
      sar_adc_ctrl_host_i.vin = 10'h0f0;
      sar_adc_ctrl_host_i.wr(8'ha2);
      repeat (30) @(posedge ref_clk_i);
      chk(track_o, 1'b1);
      t_conv(8'h82, 10'h0f0, 1'b0);
      $display("host timed acquisition done");
   endtask
   task automatic t_abort;
      sar_adc_ctrl_host_i.vin = 10'h111;
      sar_adc_ctrl_host_i.wr(8'hc9);
      wait_lvl(1'b1, 1'b0);
      repeat (20) @(posedge ref_clk_i);
      t_conv(8'hc9, 10'h2c3, 1'b1);
      $display("abort done");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      t_reset();
      t_modes();
      t_host();
      t_abort();
      end_sim();
   end
endmodule // sar_adc_ctrl_test
